// ### core/dst_regs.vh
/*
 * register map, field positions, reset values and field widths of the
 * direct switching table block.
 * assumes byte addresses on a 32-bit avalon-mm slave, one word per register.
 */
`ifndef DST_REGS_VH
`define DST_REGS_VH

// register byte offsets
`define DST_REG_CTRL 5'h00
`define DST_REG_OWN_SID 5'h04
`define DST_REG_MAX_MSDU 5'h08
`define DST_REG_STATUS 5'h0C
`define DST_REG_HITS 5'h10
`define DST_REG_ADD_FAIL 5'h14

// control register bits
`define DST_CTRL_AGG_EN 0
`define DST_CTRL_UP_CAP 1
`define DST_CTRL_BASE 2
`define DST_CTRL_CLEAR 3
`define DST_CTRL_DIRECT_EN 4

// reset values
`define DST_CTRL_RST 32'h0000_0011
`define DST_OWN_SID_RST 8'h00
`define DST_MAX_MSDU_RST 16'h0100

// status register fields
`define DST_STAT_FULL 8

// control packet field values
`define DST_CONNECTION_TYPE_DIRECTED 4'h1
`define DST_DIR_UP 1'b0
`define DST_DIR_DOWN 1'b1

// field widths
`define DST_SID_W 8
`define DST_LOCAL_NODE_IDENTIFIER_W 14
`define DST_LOCAL_CHANNEL_IDENTIFIER_W 9
`define DST_LEN_W 16

`endif

// ### core/dst_table.v
/*
 * direct switching table storage: flip-flop entries, one uplink key and one
 * downlink part per entry, with add, remove, clear and a lookup port.
 * assumes add and remove never come in the same cycle (caller decides).
 */
`timescale 1ns/1ps
`include "dst_regs.vh"

module dst_table #(
	parameter ENTRIES = 8,
	parameter IW = 4,
	parameter KW = 31,
	parameter DW = 32
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire clear_i,
	input wire add_i,
	input wire del_i,
	input wire [KW-1:0] upd_key_i,
	input wire [DW-1:0] upd_down_i,
	input wire [KW-1:0] look_key_i,
	output reg look_hit_o,
	output reg [DW-1:0] look_down_o,
	output reg add_fail_o,
	output reg [IW-1:0] count_o
);
	reg [ENTRIES-1:0] used_q;
	reg [KW-1:0] key_q [0:ENTRIES-1];
	reg [DW-1:0] down_q [0:ENTRIES-1];
	wire [ENTRIES-1:0] up_match;
	wire [ENTRIES-1:0] full_match;
	wire [ENTRIES-1:0] look_match;
	reg [IW-1:0] free_idx;
	reg free_ok;
	reg [IW-1:0] dup_idx;
	reg dup_ok;
	reg [IW-1:0] count_d;
	integer i;

	genvar g;
	generate
		for (g = 0; g < ENTRIES; g = g + 1) begin : g_ent
			assign up_match[g] = used_q[g] && key_q[g] == upd_key_i;
			// removal must match key and downlink part alike
			assign full_match[g] = up_match[g] && down_q[g] == upd_down_i;
			assign look_match[g] = used_q[g] && key_q[g] == look_key_i;
			always @(posedge clk_i) begin
				if (!reset_n_i || clear_i) begin
					used_q[g] <= 1'b0;
					key_q[g] <= {KW{1'b0}};
					down_q[g] <= {DW{1'b0}};
				end else if (add_i && ((dup_ok && dup_idx == g) ||
						(!dup_ok && free_ok && free_idx == g))) begin
					used_q[g] <= 1'b1;
					key_q[g] <= upd_key_i;
					down_q[g] <= upd_down_i;
				end else if (del_i && full_match[g]) begin
					used_q[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always @* begin
		free_idx = {IW{1'b0}};
		free_ok = 1'b0;
		dup_idx = {IW{1'b0}};
		dup_ok = 1'b0;
		look_hit_o = 1'b0;
		look_down_o = {DW{1'b0}};
		count_d = {IW{1'b0}};
		for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
			count_d = count_d + {{(IW-1){1'b0}}, used_q[i]};
			if (!used_q[i]) begin
				free_idx = i[IW-1:0];
				free_ok = 1'b1;
			end
			if (up_match[i]) begin
				dup_idx = i[IW-1:0];
				dup_ok = 1'b1;
			end
			if (look_match[i]) begin
				look_hit_o = 1'b1;
				look_down_o = down_q[i];
			end
		end
	end

	// count follows the committed entry flags, one cycle behind
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			count_o <= {IW{1'b0}};
			add_fail_o <= 1'b0;
		end else begin
			count_o <= count_d;
			add_fail_o <= add_i && !clear_i && !dup_ok && !free_ok;
		end
	end
endmodule

// ### core/dst_switch.v
/*
 * direct switching block of a power-line mac switch node: snoops control
 * packets to keep the direct table, rewrites uplink frames that hit it into
 * downlink frames, decides on packet aggregation, and in base mode holds the
 * accepting connection request until the target has accepted.
 * assumes all frame and control inputs come from logic on clk_i; frames
 * already carry the normal switching verdict in in_qualifies_i.
 */
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "dst_regs.vh"

// Notes on behaviour
// - add an entry on a directed downlink connection request aimed at us
// - entry key is packet switch, node, channel; downlink part from request
// - remove the entry on a directed downlink close aimed at us
// - removal finds the entry by the same key and downlink fields
// - a hit rewrites switch, node, channel and no-aggregation flag
// - a rewritten frame leaves as a downlink frame, direction bit one
// - each entry holds origin and destination connection identifiers
// - only connections switched locally by this switch enter the table
// - each entry stores the destination no-aggregation value
// - base sends accepting request to initiator only after target is set
// - aggregation is optional and can be switched off entirely
// - base fills downlink no-aggregation flag from reported path capability
// - last switch never aggregates for an incapable destination
// - no aggregation toward a next switch known to be incapable
// - an aggregated msdu never exceeds the most robust burst capacity
// - only uplink frames meeting normal switching are direct candidates
module dst_switch #(
	parameter ENTRIES = 8,
	parameter IW = 4
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire [4:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	input wire ctl_valid_i,
	input wire ctl_direction_bit_i,
	input wire [3:0] ctl_connection_type_i,
	input wire ctl_close_flag_i,
	input wire ctl_direct_flag_i,
	input wire [`DST_SID_W-1:0] ctl_direct_switch_identifier_i,
	input wire [`DST_SID_W-1:0] ctl_packet_switch_identifier_i,
	input wire [`DST_LOCAL_NODE_IDENTIFIER_W-1:0] ctl_packet_node_identifier_i,
	input wire [`DST_LOCAL_CHANNEL_IDENTIFIER_W-1:0] ctl_connection_channel_identifier_i,
	input wire [`DST_SID_W-1:0] ctl_destination_switch_identifier_i,
	input wire [`DST_LOCAL_NODE_IDENTIFIER_W-1:0] ctl_destination_node_identifier_i,
	input wire [`DST_LOCAL_CHANNEL_IDENTIFIER_W-1:0] ctl_destination_channel_identifier_i,
	input wire ctl_destination_no_aggregation_i,
	input wire init_request_i,
	input wire target_accept_i,
	output reg send_accept_o,
	input wire in_valid_i,
	output reg in_ready_o,
	input wire in_qualifies_i,
	input wire in_direction_bit_i,
	input wire [`DST_SID_W-1:0] in_switch_identifier_i,
	input wire [`DST_LOCAL_NODE_IDENTIFIER_W-1:0] in_node_identifier_i,
	input wire [`DST_LOCAL_CHANNEL_IDENTIFIER_W-1:0] in_channel_identifier_i,
	input wire in_no_aggregation_flag_i,
	input wire in_next_capable_i,
	input wire in_dest_path_capable_i,
	input wire [`DST_LEN_W-1:0] in_length_i,
	output reg out_valid_o,
	input wire out_ready_i,
	output reg out_forward_o,
	output reg out_direct_o,
	output reg out_direction_bit_o,
	output reg [`DST_SID_W-1:0] out_switch_identifier_o,
	output reg [`DST_LOCAL_NODE_IDENTIFIER_W-1:0] out_node_identifier_o,
	output reg [`DST_LOCAL_CHANNEL_IDENTIFIER_W-1:0] out_channel_identifier_o,
	output reg out_no_aggregation_flag_o,
	output reg out_aggregate_o,
	output reg [`DST_LEN_W-1:0] out_length_o
);
	localparam KW = `DST_SID_W + `DST_LOCAL_NODE_IDENTIFIER_W + `DST_LOCAL_CHANNEL_IDENTIFIER_W;
	localparam DW = KW + 1;
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT_TGT = 1'b1;

	reg [31:0] ctrl_q;
	reg [`DST_SID_W-1:0] own_sid_q;
	reg [`DST_LEN_W-1:0] max_msdu_q;
	reg [15:0] hits_q;
	reg [15:0] add_fail_cnt_q;
	reg [`DST_LEN_W:0] agg_used_q;
	reg setup_state_q;
	reg clear_q;
	reg [31:0] wmask;
	reg [31:0] rdata_d;
	reg agg_ok;
	reg [`DST_LEN_W:0] agg_sum;
	wire bus_req;
	wire bus_commit_wr;
	wire directed;
	wire for_us;
	wire tbl_add;
	wire tbl_del;
	wire [KW-1:0] upd_key;
	wire [DW-1:0] upd_down;
	wire [KW-1:0] look_key;
	wire look_hit;
	wire [DW-1:0] look_down;
	wire add_fail;
	wire [IW-1:0] count;
	wire accept;
	wire direct_hit;
	wire [`DST_SID_W-1:0] nx_sid;
	wire nx_nad;
	wire nx_dir;

	// bus: request seen with waitrequest high, answered one cycle later
	assign bus_req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
	assign bus_commit_wr = avs_write_i && !avs_waitrequest_o;

	always @* begin
		wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		rdata_d = 32'h0000_0000;
		if (avs_address_i == `DST_REG_CTRL) begin
			rdata_d = ctrl_q;
		end else if (avs_address_i == `DST_REG_OWN_SID) begin
			rdata_d[`DST_SID_W-1:0] = own_sid_q;
		end else if (avs_address_i == `DST_REG_MAX_MSDU) begin
			rdata_d[`DST_LEN_W-1:0] = max_msdu_q;
		end else if (avs_address_i == `DST_REG_STATUS) begin
			rdata_d[IW-1:0] = count;
			rdata_d[`DST_STAT_FULL] = count == ENTRIES[IW-1:0];
		end else if (avs_address_i == `DST_REG_HITS) begin
			rdata_d[15:0] = hits_q;
		end else if (avs_address_i == `DST_REG_ADD_FAIL) begin
			rdata_d[15:0] = add_fail_cnt_q;
		end
	end

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
			ctrl_q <= `DST_CTRL_RST;
			own_sid_q <= `DST_OWN_SID_RST;
			max_msdu_q <= `DST_MAX_MSDU_RST;
			clear_q <= 1'b0;
		end else begin
			avs_waitrequest_o <= !bus_req;
			clear_q <= 1'b0;
			if (bus_req && avs_read_i) begin
				avs_readdata_o <= rdata_d;
			end
			if (bus_commit_wr) begin
				if (avs_address_i == `DST_REG_CTRL) begin
					// reserved bits stay zero so they read back as zero
					ctrl_q <= ((ctrl_q & ~wmask) | (avs_writedata_i & wmask)) &
						32'h0000_001F;
					ctrl_q[`DST_CTRL_CLEAR] <= 1'b0;
					clear_q <= avs_writedata_i[`DST_CTRL_CLEAR] &&
						avs_byteenable_i[0];
				end else if (avs_address_i == `DST_REG_OWN_SID) begin
					own_sid_q <= (own_sid_q & ~wmask[`DST_SID_W-1:0]) |
						(avs_writedata_i[`DST_SID_W-1:0] &
						wmask[`DST_SID_W-1:0]);
				end else if (avs_address_i == `DST_REG_MAX_MSDU) begin
					max_msdu_q <= (max_msdu_q & ~wmask[`DST_LEN_W-1:0]) |
						(avs_writedata_i[`DST_LEN_W-1:0] &
						wmask[`DST_LEN_W-1:0]);
				end
			end
		end
	end

	// control packet snoop; only packets naming us as direct switch count
	assign directed = ctl_valid_i && ctl_direction_bit_i == `DST_DIR_DOWN &&
		ctl_connection_type_i == `DST_CONNECTION_TYPE_DIRECTED && ctl_direct_flag_i;
	assign for_us = directed && ctl_direct_switch_identifier_i == own_sid_q;
	assign tbl_add = for_us && !ctl_close_flag_i;
	assign tbl_del = for_us && ctl_close_flag_i;
	assign upd_key = {ctl_packet_switch_identifier_i,
		ctl_packet_node_identifier_i,
		ctl_connection_channel_identifier_i};
	assign upd_down = {ctl_destination_switch_identifier_i,
		ctl_destination_node_identifier_i,
		ctl_destination_channel_identifier_i,
		ctl_destination_no_aggregation_i};
	assign look_key = {in_switch_identifier_i, in_node_identifier_i,
		in_channel_identifier_i};

	dst_table #(
		.ENTRIES(ENTRIES),
		.IW(IW),
		.KW(KW),
		.DW(DW)
	) u_table (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.clear_i(clear_q),
		.add_i(tbl_add),
		.del_i(tbl_del),
		.upd_key_i(upd_key),
		.upd_down_i(upd_down),
		.look_key_i(look_key),
		.look_hit_o(look_hit),
		.look_down_o(look_down),
		.add_fail_o(add_fail),
		.count_o(count)
	);

	// frame path: one slot, so a frame and its verdict leave together
	assign accept = in_valid_i && in_ready_o;
	assign direct_hit = ctrl_q[`DST_CTRL_DIRECT_EN] && in_qualifies_i &&
		in_direction_bit_i == `DST_DIR_UP && look_hit;
	assign nx_sid = direct_hit ? look_down[DW-1:DW-`DST_SID_W] :
		in_switch_identifier_i;
	assign nx_dir = direct_hit ? `DST_DIR_DOWN : in_direction_bit_i;
	// base originates downlink data and fills the flag from the path
	assign nx_nad = direct_hit ? look_down[0] :
		(ctrl_q[`DST_CTRL_BASE] && in_direction_bit_i == `DST_DIR_DOWN) ?
		!in_dest_path_capable_i : in_no_aggregation_flag_i;

	always @* begin
		agg_ok = 1'b0;
		if (ctrl_q[`DST_CTRL_AGG_EN]) begin
			if (nx_dir == `DST_DIR_UP) begin
				agg_ok = ctrl_q[`DST_CTRL_UP_CAP];
			end else if (nx_sid == own_sid_q) begin
				agg_ok = !nx_nad;
			end else begin
				agg_ok = in_next_capable_i;
			end
		end
		agg_sum = agg_used_q + {1'b0, in_length_i};
		// a frame alone above the limit cannot join any aggregate
		if (agg_sum > {1'b0, max_msdu_q} || in_length_i > max_msdu_q) begin
			agg_ok = 1'b0;
		end
	end

	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
			out_forward_o <= 1'b0;
			out_direct_o <= 1'b0;
			out_direction_bit_o <= 1'b0;
			out_switch_identifier_o <= {`DST_SID_W{1'b0}};
			out_node_identifier_o <= {`DST_LOCAL_NODE_IDENTIFIER_W{1'b0}};
			out_channel_identifier_o <= {`DST_LOCAL_CHANNEL_IDENTIFIER_W{1'b0}};
			out_no_aggregation_flag_o <= 1'b0;
			out_aggregate_o <= 1'b0;
			out_length_o <= {`DST_LEN_W{1'b0}};
			agg_used_q <= {(`DST_LEN_W+1){1'b0}};
			hits_q <= 16'h0000;
			add_fail_cnt_q <= 16'h0000;
		end else begin
			if (add_fail && add_fail_cnt_q != 16'hFFFF) begin
				add_fail_cnt_q <= add_fail_cnt_q + 16'h0001;
			end
			if (accept) begin
				in_ready_o <= 1'b0;
				out_valid_o <= 1'b1;
				out_forward_o <= in_qualifies_i;
				out_direct_o <= direct_hit;
				out_direction_bit_o <= nx_dir;
				out_switch_identifier_o <= nx_sid;
				out_node_identifier_o <= direct_hit ?
					look_down[DW-`DST_SID_W-1:`DST_LOCAL_CHANNEL_IDENTIFIER_W+1] :
					in_node_identifier_i;
				out_channel_identifier_o <= direct_hit ?
					look_down[`DST_LOCAL_CHANNEL_IDENTIFIER_W:1] : in_channel_identifier_i;
				out_no_aggregation_flag_o <= nx_nad;
				out_aggregate_o <= agg_ok && agg_used_q != 0;
				out_length_o <= in_length_i;
				// a frame kept out of aggregation closes the running msdu
				agg_used_q <= agg_ok ? agg_sum : {(`DST_LEN_W+1){1'b0}};
				if (direct_hit && hits_q != 16'hFFFF) begin
					hits_q <= hits_q + 16'h0001;
				end
			end else if (out_valid_o && out_ready_i) begin
				out_valid_o <= 1'b0;
				in_ready_o <= 1'b1;
			end
		end
	end

	// base mode: hold the initiator's accept until the target has accepted
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			setup_state_q <= ST_IDLE;
			send_accept_o <= 1'b0;
		end else begin
			send_accept_o <= 1'b0;
			case (setup_state_q)
				ST_IDLE: begin
					if (ctrl_q[`DST_CTRL_BASE] && init_request_i) begin
						setup_state_q <= ST_WAIT_TGT;
					end
				end
				default: begin
					if (!ctrl_q[`DST_CTRL_BASE]) begin
						setup_state_q <= ST_IDLE;
					end else if (target_accept_i) begin
						send_accept_o <= 1'b1;
						setup_state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ### core/dst_table_fix.v
/*
 * holds no logic: the table storage lives in dst_table.v.
 * assumes nothing of its surroundings.
 */

// ### bench/dst_switch_assertions.sv
/*
 * handshake and output checker for dst_switch, bound to every instance.
 * assumes the single clock clk_i and the synchronous reset reset_n_i.
 */
`timescale 1ns/1ps
`include "dst_regs.vh"
module dst_switch_assertions (
	input wire clk_i,
	input wire reset_n_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire in_valid_i,
	input wire in_ready_o,
	input wire in_qualifies_i,
	input wire in_direction_bit_i,
	input wire out_valid_o,
	input wire out_ready_i,
	input wire out_forward_o,
	input wire out_direct_o,
	input wire out_direction_bit_o,
	input wire [`DST_SID_W-1:0] out_switch_identifier_o,
	input wire target_accept_i,
	input wire send_accept_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence take_s;
		in_valid_i && in_ready_o;
	endsequence
	sequence done_s;
		out_valid_o && out_ready_i;
	endsequence
	bus_answer_a: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o) else $error("bus late");
	wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	take_busy_a: assert property (take_s |=> out_valid_o && !in_ready_o)
		else $error("frame not taken");
	out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o
		&& $stable(out_switch_identifier_o) && $stable(out_direct_o))
		else $error("output moved while stalled");
	out_release_a: assert property (done_s |=> !out_valid_o && in_ready_o)
		else $error("output not released");
	direct_dir_a: assert property (out_valid_o && out_direct_o |->
		out_direction_bit_o) else $error("direct frame not downlink");
	direct_cause_a: assert property (take_s ##1 out_direct_o |->
		$past(in_qualifies_i && !in_direction_bit_i))
		else $error("direct switch of a non candidate");
	forward_flag_a: assert property (take_s |=>
		out_forward_o == $past(in_qualifies_i)) else $error("forward flag");
	accept_once_a: assert property (send_accept_o |=> !send_accept_o)
		else $error("accept not a pulse");
	accept_cause_a: assert property (send_accept_o |->
		$past(target_accept_i)) else $error("accept without target");
endmodule

bind dst_switch dst_switch_assertions u_dst_switch_assertions (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
	.in_qualifies_i(in_qualifies_i), .in_direction_bit_i(in_direction_bit_i),
	.out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
	.out_forward_o(out_forward_o), .out_direct_o(out_direct_o),
	.out_direction_bit_o(out_direction_bit_o),
	.out_switch_identifier_o(out_switch_identifier_o),
	.target_accept_i(target_accept_i), .send_accept_o(send_accept_o));

// ### bench/dst_switch_peer.sv
/*
 * neighbour node taking frames from the switch, with random stalls.
 * assumes it runs on the switch clock and reset.
 */
`timescale 1ns/1ps
module dst_switch_peer (
	input wire clk_i,
	input wire reset_n_i,
	input wire slow_i,
	input wire valid_i,
	output logic ready_o
);
	logic [15:0] lfsr_q;
	initial ready_o = 1'b0;
	// stalls at random only when slow; fast runs raise ready one cycle after valid, for every frame
	always @(posedge clk_i) begin
		lfsr_q <= reset_n_i ? {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]} : 16'hace1;
		ready_o <= reset_n_i & valid_i & (!slow_i | lfsr_q[0]);
	end
endmodule

// ### bench/dst_switch_tb_top.sv
/*
 * self-checking bench for dst_switch: registers, table snoop, direct
 * switching, aggregation and base setup; assumes 100 MHz clk_i.
 */
`timescale 1ns/1ps
`include "dst_regs.vh"
module dst_switch_tb_top;
logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, slow;
logic [4:0] avs_address_i;
logic [31:0] avs_writedata_i, avs_readdata_o, rs, ctrl_m;
logic [3:0] avs_byteenable_i, ctl_connection_type_i;
logic ctl_valid_i, ctl_direction_bit_i, ctl_close_flag_i, ctl_direct_flag_i;
logic [7:0] ctl_direct_switch_identifier_i, ctl_packet_switch_identifier_i;
logic [7:0] ctl_destination_switch_identifier_i, in_switch_identifier_i;
logic [13:0] ctl_packet_node_identifier_i, ctl_destination_node_identifier_i;
logic [8:0] ctl_connection_channel_identifier_i, in_channel_identifier_i;
logic [8:0] ctl_destination_channel_identifier_i, out_channel_identifier_o;
logic [13:0] in_node_identifier_i, out_node_identifier_o, kn, dn;
logic ctl_destination_no_aggregation_i, init_request_i, target_accept_i;
logic send_accept_o, in_valid_i, in_ready_o, in_qualifies_i, e_nad, sync;
logic in_direction_bit_i, in_no_aggregation_flag_i, in_next_capable_i;
logic in_dest_path_capable_i, out_valid_o, out_ready_i, out_forward_o;
logic out_direct_o, out_direction_bit_o, out_no_aggregation_flag_o;
logic out_aggregate_o;
logic [7:0] out_switch_identifier_o, ks, ds, own_m;
logic [8:0] kc, dc;
logic [15:0] in_length_i, out_length_o;
int bad_count, checked, used, max_m;

dst_switch u_dst_switch (.*);
dst_switch_peer u_dst_switch_peer (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.slow_i(slow), .valid_i(out_valid_o), .ready_o(out_ready_i));

initial begin
	clk_i = 1'b0;
	forever #5 clk_i = ~clk_i;
end

function automatic logic [31:0] xs(input logic [31:0] x);
	x ^= x << 13;
	x ^= x >> 17;
	x ^= x << 5;
	return x;
endfunction

// expected no-aggregation flag of a frame leaving the switch
function automatic logic exp_nad(input logic h, dr, a);
	return h ? e_nad : ((ctrl_m[2] & dr) ? !in_dest_path_capable_i : a);
endfunction

task results;
	if (bad_count == 0 && checked > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask

task cmp(input logic [31:0] g, input logic [31:0] e);
	checked++;
	if (g !== e) begin
		bad_count++;
		$display("Error %0t got %h exp %h", $time, g, e);
	end
endtask

task bus(input logic we, input logic [4:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
	avs_write_i <= we;
	avs_read_i <= !we;
	avs_address_i <= ad;
	avs_writedata_i <= wd;
	do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
	rd = avs_readdata_o;
	avs_write_i <= 1'b0;
	avs_read_i <= 1'b0;
	@(posedge clk_i);
endtask

task wr(input logic [4:0] ad, input logic [31:0] wd);
	logic [31:0] r;
	bus(1'b1, ad, wd, r);
endtask

task rdc(input logic [4:0] ad, input logic [31:0] e);
	logic [31:0] r;
	bus(1'b0, ad, 32'h0, r);
	cmp(r, e);
endtask

task ctl(input logic [3:0] ty, input logic cl, di, dr, input logic [7:0] d);
	ctl_valid_i <= 1'b1;
	ctl_connection_type_i <= ty;
	ctl_close_flag_i <= cl;
	ctl_direct_flag_i <= di;
	ctl_direction_bit_i <= dr;
	ctl_direct_switch_identifier_i <= d;
	@(posedge clk_i);
	ctl_valid_i <= 1'b0;
	@(posedge clk_i);
endtask

task pulse(input logic t);
	if (t)
		target_accept_i <= 1'b1;
	else
		init_request_i <= 1'b1;
	@(posedge clk_i);
	{target_accept_i, init_request_i} <= 2'b00;
	@(posedge clk_i);
endtask

task frame(input logic q, dr, h, input logic [7:0] s, input logic [13:0] n,
		input logic [8:0] c, input logic a, input logic [15:0] len);
	logic na, okc, ok;
	in_valid_i <= 1'b1;
	in_qualifies_i <= q;
	in_direction_bit_i <= dr;
	in_switch_identifier_i <= s;
	in_node_identifier_i <= n;
	in_channel_identifier_i <= c;
	in_no_aggregation_flag_i <= a;
	in_length_i <= len;
	do @(posedge clk_i); while (in_ready_o !== 1'b1);
	in_valid_i <= 1'b0;
	#1;
	na = exp_nad(h, dr, a);
	okc = ctrl_m[0] & (dr ? (s == own_m ? !na : in_next_capable_i)
		: ctrl_m[1]) & (len <= max_m);
	ok = okc & (used + len <= max_m);
	cmp({out_direction_bit_o, out_switch_identifier_o,
		out_node_identifier_o, out_channel_identifier_o},
		h ? {1'b1, ds, dn, dc} : {dr, s, n, c});
	cmp({out_direct_o, out_forward_o,
		out_no_aggregation_flag_o, out_length_o}, {h, q, na, len});
	if (sync & !h & q)
		cmp(out_aggregate_o, ok & (used != 0));
	// after a hit or a frame that fails normal switching the running size is not tracked
	if (h | !q)
		sync = 1'b0;
	else if (!okc) begin
		sync = 1'b1;
		used = 0;
	end else
		used = ok ? used + len : 0;
	do @(posedge clk_i); while (!(out_valid_o & out_ready_i));
endtask

task kf(input logic q, dr, h);
	frame(q, dr, h, ks, kn, kc, 1'b0, 16'h0020);
endtask

initial begin
	repeat (5000) @(posedge clk_i);
	bad_count++;
	results;
end

initial begin
	{reset_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i,
		ctl_valid_i, ctl_direction_bit_i, ctl_connection_type_i,
		ctl_close_flag_i, ctl_direct_flag_i, ctl_direct_switch_identifier_i,
		ctl_destination_no_aggregation_i, init_request_i, target_accept_i,
		in_valid_i, in_qualifies_i, in_direction_bit_i, in_switch_identifier_i,
		in_node_identifier_i, in_channel_identifier_i, in_length_i, slow,
		in_no_aggregation_flag_i, in_next_capable_i, in_dest_path_capable_i} = '0;
	{bad_count, checked, used, sync, e_nad} = '0;
	sync = 1'b1;
	avs_byteenable_i = 4'hf;
	rs = 32'h0946_2f8b;
	{ks, kn, kc} = rs[30:0];
	rs = xs(rs);
	{ds, dn, dc} = rs[30:0];
	{ctl_packet_switch_identifier_i, ctl_packet_node_identifier_i} = {ks, kn};
	ctl_connection_channel_identifier_i = kc;
	{ctl_destination_switch_identifier_i, ctl_destination_node_identifier_i,
		ctl_destination_channel_identifier_i} = {ds, dn, dc};
	ctrl_m = `DST_CTRL_RST;
	own_m = 8'h05;
	max_m = 32'h0000_0180;
	repeat (5) @(posedge clk_i);
	reset_n_i <= 1'b1;
	rdc(`DST_REG_CTRL, `DST_CTRL_RST);
	rdc(`DST_REG_OWN_SID, `DST_OWN_SID_RST);
	rdc(`DST_REG_MAX_MSDU, `DST_MAX_MSDU_RST);
	wr(`DST_REG_OWN_SID, 32'h0000_0005);
	avs_byteenable_i <= 4'h1;
	wr(`DST_REG_MAX_MSDU, 32'hffff_ff80);
	avs_byteenable_i <= 4'hf;
	rdc(`DST_REG_MAX_MSDU, 32'h0000_0180);
	wr(5'h18, 32'hffff_ffff);
	rdc(5'h18, 32'h0000_0000);
	ctl_destination_no_aggregation_i <= 1'b1;
	e_nad = 1'b1;
	ctl(4'h2, 1'b0, 1'b1, 1'b1, 8'h05);
	ctl(4'h1, 1'b0, 1'b1, 1'b0, 8'h05);
	ctl(4'h1, 1'b0, 1'b0, 1'b1, 8'h05);
	ctl(4'h1, 1'b0, 1'b1, 1'b1, 8'h06);
	rdc(`DST_REG_STATUS, 32'h0000_0000);
	kf(1'b1, 1'b0, 1'b0);
	ctl(4'h1, 1'b0, 1'b1, 1'b1, 8'h05);
	rdc(`DST_REG_STATUS, 32'h0000_0001);
	kf(1'b1, 1'b0, 1'b1);
	kf(1'b0, 1'b0, 1'b0);
	kf(1'b1, 1'b1, 1'b0);
	rdc(`DST_REG_HITS, 32'h0000_0001);
	ctl_destination_no_aggregation_i <= 1'b0;
	ctl(4'h1, 1'b1, 1'b1, 1'b1, 8'h05);
	rdc(`DST_REG_STATUS, 32'h0000_0001);
	ctl_destination_no_aggregation_i <= 1'b1;
	ctl(4'h1, 1'b1, 1'b1, 1'b1, 8'h05);
	rdc(`DST_REG_STATUS, 32'h0000_0000);
	kf(1'b1, 1'b0, 1'b0);
	ctl(4'h1, 1'b0, 1'b1, 1'b1, 8'h05);
	rdc(`DST_REG_STATUS, 32'h0000_0001);
	wr(`DST_REG_CTRL, 32'h0000_0019);
	// clear lands one cycle after the commit, the count one cycle later
	@(posedge clk_i);
	rdc(`DST_REG_STATUS, 32'h0000_0000);
	rdc(`DST_REG_CTRL, 32'h0000_0011);
	ctrl_m = 32'h0000_0013;
	wr(`DST_REG_CTRL, ctrl_m);
	frame(1'b1, 1'b0, 1'b0, ks, kn, kc, 1'b0, 16'h0100);
	frame(1'b1, 1'b0, 1'b0, ks, kn, kc, 1'b0, 16'h0080);
	frame(1'b1, 1'b0, 1'b0, ks, kn, kc, 1'b0, 16'hffff);
	for (int i = 0; i < 40; i++) begin
		rs = xs(rs);
		if (i % 8 == 0) begin
			ctrl_m = {27'h0, 1'b1, 2'b00, rs[1:0]};
			wr(`DST_REG_CTRL, ctrl_m);
		end
		in_next_capable_i <= rs[2];
		slow <= rs[3];
		frame(1'b1, rs[4], 1'b0, rs[5] ? own_m : rs[15:8], rs[29:16],
			rs[31:23], rs[4] ? rs[6] : !ctrl_m[1], {9'h0, rs[13:7]});
	end
	ctrl_m = 32'h0000_0014;
	wr(`DST_REG_CTRL, ctrl_m);
	pulse(1'b1);
	cmp(send_accept_o, 32'h0);
	pulse(1'b0);
	cmp(send_accept_o, 32'h0);
	pulse(1'b1);
	cmp(send_accept_o, 32'h1);
	for (int i = 0; i < 2; i++) begin
		in_dest_path_capable_i <= i[0];
		frame(1'b1, 1'b1, 1'b0, 8'h07, 14'h0002, 9'h003, i[0], 16'h0008);
	end
	results;
end
endmodule
